// [rtl/dsgc_gate_ctrl.sv]
/*
  Clock gating control with run, sleep and deep-sleep gating registers, APB register slave,
  gated-unit access faulting and a level interrupt.
  Assumes sleep_now, deep_now and unit_sel come from logic on core_clk; the real clock gates
  sit outside and follow unit_clk_en.
*/
// The APB register port was chosen for this implementation.
`default_nettype none
module dsgc_gate_ctrl
  import dsgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic core_ce,
  input wire dsgc_apb_req_t apb_req,
  output dsgc_apb_rsp_t apb_rsp,
  input wire logic sleep_now,
  input wire logic deep_now,
  input wire logic [NUM_UNITS-1:0] unit_sel,
  output logic [NUM_UNITS-1:0] unit_clk_en,
  output logic [NUM_UNITS-1:0] unit_fault,
  output logic irq
);
  dsgc_state_t st_reg;
  dsgc_state_t st_next;
  dsgc_mode_t mode_now;
  logic [31:0] gate_sel;
  logic [31:0] rd_val;
  logic rd_err;
  logic capture;
  logic done;
  logic wr_acc;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] clr;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata;

  assign addr = apb_req.paddr;
  assign wdata = apb_req.pwdata;

  // read data is latched a cycle early so prdata comes from a flop; a frozen
  // clock enable during setup just costs one wait state
  assign capture = apb_req.psel && core_ce && !(apb_req.penable && st_reg.rsp_ok);
  assign done = apb_req.psel && apb_req.penable && core_ce && st_reg.rsp_ok;
  assign wr_acc = done && apb_req.pwrite && !st_reg.pslverr;

  // the deep and sleep registers only count with auto-gating selected
  always_comb begin
    if (st_reg.auto_gating_select && deep_now) begin
      mode_now = DSGC_DEEP;
    end else if (st_reg.auto_gating_select && sleep_now) begin
      mode_now = DSGC_SLEEP;
    end else begin
      mode_now = DSGC_RUN;
    end
  end

  always_comb begin
    case (mode_now)
      DSGC_DEEP: gate_sel = st_reg.deep_gate;
      DSGC_SLEEP: gate_sel = st_reg.sleep_gate;
      default: gate_sel = st_reg.run_gate;
    endcase
  end

  // fault uses the enable actually driven to the gates, not the pending one
  assign unit_fault = unit_sel & ~st_reg.clk_en;

  always_comb begin
    evt = EVT_RESET;
    evt[EVT_FAULT] = |unit_fault;
    evt[EVT_DEEP] = (mode_now == DSGC_DEEP) && (st_reg.mode != DSGC_DEEP);
    evt[EVT_WAKE] = (mode_now == DSGC_RUN) && (st_reg.mode != DSGC_RUN);
  end

  // reserved bits are masked on read and write alike
  always_comb begin
    rd_err = 1'b0;
    rd_val = READ_ZERO;
    if (addr == RUN_CFG_OFF) begin
      rd_val[ACG_BIT] = st_reg.auto_gating_select;
    end else if (addr == RUN_GATE_OFF) begin
      rd_val = st_reg.run_gate & GATE_MASK;
    end else if (addr == SLEEP_GATE_OFF) begin
      rd_val = st_reg.sleep_gate & GATE_MASK;
    end else if (addr == DEEP_GATE_OFF) begin
      rd_val = st_reg.deep_gate & GATE_MASK;
    end else if (addr == IRQ_STATUS_OFF) begin
      rd_val[NUM_EVT-1:0] = st_reg.irq_status;
    end else if (addr == IRQ_ENABLE_OFF) begin
      rd_val[NUM_EVT-1:0] = st_reg.irq_enable;
    end else if (addr == IRQ_CLEAR_OFF) begin
      rd_val = READ_ZERO;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_comb begin
    clr = EVT_RESET;
    if (wr_acc && (addr == IRQ_CLEAR_OFF)) begin
      clr = wdata[NUM_EVT-1:0];
    end
  end

  always_comb begin
    st_next = st_reg;
    if (core_ce) begin
      st_next.clk_en = dsgc_units(gate_sel);
      st_next.mode = mode_now;
      if (capture) begin
        st_next.prdata = rd_val;
        st_next.pslverr = rd_err;
        st_next.rsp_ok = 1'b1;
      end else if (done) begin
        st_next.rsp_ok = 1'b0;
      end
      if (wr_acc) begin
        if (addr == RUN_CFG_OFF) begin
          st_next.auto_gating_select = wdata[ACG_BIT];
        end else if (addr == RUN_GATE_OFF) begin
          st_next.run_gate = wdata & GATE_MASK;
        end else if (addr == SLEEP_GATE_OFF) begin
          st_next.sleep_gate = wdata & GATE_MASK;
        end else if (addr == DEEP_GATE_OFF) begin
          st_next.deep_gate = wdata & GATE_MASK;
        end else if (addr == IRQ_ENABLE_OFF) begin
          st_next.irq_enable = wdata[NUM_EVT-1:0];
        end
      end
      // a new event beats a clear in the same cycle
      st_next.irq_status = (st_reg.irq_status & ~clr) | evt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= DSGC_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign unit_clk_en = st_reg.clk_en;
  assign irq = |(st_reg.irq_status & st_reg.irq_enable);
  assign apb_rsp.pready = done;
  assign apb_rsp.pslverr = st_reg.pslverr;
  assign apb_rsp.prdata = st_reg.prdata;

  a_fault_gated_port: assert property (@(posedge core_clk) disable iff (!resetn)
    (unit_sel[0] && !unit_clk_en[0]) |-> unit_fault[0])
    else $error("access to gated port gave no fault");

  a_no_fault_clocked: assert property (@(posedge core_clk) disable iff (!resetn)
    (unit_sel[UNIT_PHY] && unit_clk_en[UNIT_PHY]) |-> !unit_fault[UNIT_PHY])
    else $error("fault raised on clocked unit");

  a_deep_selects: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && st_reg.auto_gating_select && deep_now) |=> (unit_clk_en == dsgc_units($past(st_reg.deep_gate))))
    else $error("deep sleep did not use deep gating register");

  a_run_no_acg: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && !st_reg.auto_gating_select) |=> (unit_clk_en == dsgc_units($past(st_reg.run_gate))))
    else $error("without auto-gating run register not used");

  a_sleep_selects: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && st_reg.auto_gating_select && sleep_now && !deep_now)
      |=> (unit_clk_en == dsgc_units($past(st_reg.sleep_gate))))
    else $error("sleep did not use sleep gating register");

  a_phy_bit_map: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && st_reg.auto_gating_select && deep_now) |=> (unit_clk_en[UNIT_PHY] == $past(st_reg.deep_gate[PHY_BIT])))
    else $error("physical layer enable not from bit 30");

  a_mac_bit_map: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && !st_reg.auto_gating_select) |=> (unit_clk_en[UNIT_MAC] == $past(st_reg.run_gate[MAC_BIT])))
    else $error("media access enable not from bit 28");

  a_deep_write: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_acc && addr == DEEP_GATE_OFF) |=> (st_reg.deep_gate == ($past(wdata) & GATE_MASK)))
    else $error("deep gating write not stored");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (done && !apb_req.pwrite && addr == DEEP_GATE_OFF) |-> ((apb_rsp.prdata & ~GATE_MASK) == READ_ZERO))
    else $error("reserved bits read non-zero");

  // an enable write in the same cycle may legally mask the new event
  a_fault_irq: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && (|unit_fault) && st_reg.irq_enable[EVT_FAULT] && !(wr_acc && addr == IRQ_ENABLE_OFF)) |=> irq)
    else $error("enabled fault event gave no interrupt");

  a_fault_all_units: assert property (@(posedge core_clk) disable iff (!resetn)
    unit_fault == (unit_sel & ~unit_clk_en))
    else $error("fault vector does not follow gated selects");

  a_fault_sets_status: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && (|unit_fault)) |=> st_reg.irq_status[EVT_FAULT])
    else $error("fault event not recorded");

  a_fault_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && st_reg.irq_status[EVT_FAULT] && !clr[EVT_FAULT]) |=> st_reg.irq_status[EVT_FAULT])
    else $error("fault status dropped without clear");

  // a frozen enable must leave the gates alone, whatever the power state does
  a_freeze_gates: assert property (@(posedge core_clk) disable iff (!resetn)
    !core_ce |=> $stable(unit_clk_en))
    else $error("gating changed while frozen");

  a_freeze_irq: assert property (@(posedge core_clk) disable iff (!resetn)
    !core_ce |=> $stable(irq))
    else $error("interrupt changed while frozen");

  a_freeze_no_ready: assert property (@(posedge core_clk) disable iff (!resetn)
    !core_ce |-> !apb_rsp.pready)
    else $error("ready given while frozen");

  a_ready_in_access: assert property (@(posedge core_clk) disable iff (!resetn)
    apb_rsp.pready |-> (apb_req.psel && apb_req.penable))
    else $error("ready outside an access phase");

  a_deep_read_back: assert property (@(posedge core_clk) disable iff (!resetn)
    (done && !apb_req.pwrite && addr == DEEP_GATE_OFF) |-> (apb_rsp.prdata == (st_reg.deep_gate & GATE_MASK)))
    else $error("deep gating read back wrong");

  a_deep_no_err: assert property (@(posedge core_clk) disable iff (!resetn)
    (done && addr == DEEP_GATE_OFF) |-> !apb_rsp.pslverr)
    else $error("deep gating access errored");

  a_run_write: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_acc && addr == RUN_GATE_OFF) |=> (st_reg.run_gate == ($past(wdata) & GATE_MASK)))
    else $error("run gating write not stored");

  a_sleep_write: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_acc && addr == SLEEP_GATE_OFF) |=> (st_reg.sleep_gate == ($past(wdata) & GATE_MASK)))
    else $error("sleep gating write not stored");

  a_acg_write: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_acc && addr == RUN_CFG_OFF) |=> (st_reg.auto_gating_select == $past(wdata[ACG_BIT])))
    else $error("auto-gating select not stored");

  a_sleep_no_acg: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && !st_reg.auto_gating_select && sleep_now) |=> (unit_clk_en == dsgc_units($past(st_reg.run_gate))))
    else $error("sleep register used without auto-gating");

  a_phy_run_map: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && !st_reg.auto_gating_select) |=> (unit_clk_en[UNIT_PHY] == $past(st_reg.run_gate[PHY_BIT])))
    else $error("physical layer run enable not from bit 30");

  a_mac_deep_map: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && st_reg.auto_gating_select && deep_now) |=> (unit_clk_en[UNIT_MAC] == $past(st_reg.deep_gate[MAC_BIT])))
    else $error("media access deep enable not from bit 28");

  a_port_deep_map: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && st_reg.auto_gating_select && deep_now)
      |=> (unit_clk_en[PORT_MSB:0] == $past(st_reg.deep_gate[PORT_MSB:0])))
    else $error("port enables not from bits 6..0");

  // reserved bits can never be stored, so nothing downstream can see them
  a_reserved_stored: assert property (@(posedge core_clk) disable iff (!resetn)
    (((st_reg.run_gate | st_reg.sleep_gate | st_reg.deep_gate) & ~GATE_MASK) == READ_ZERO))
    else $error("reserved gating bit stored");

  a_run_cfg_read: assert property (@(posedge core_clk) disable iff (!resetn)
    (done && !apb_req.pwrite && addr == RUN_CFG_OFF) |-> (apb_rsp.prdata[ACG_BIT-1:0] == 27'h0000000))
    else $error("configuration reserved bits read non-zero");
endmodule : dsgc_gate_ctrl
`default_nettype wire

// [rtl/dsgc_pkg.sv]
/*
  Constants, carrier structs and state layout for the deep-sleep clock gating control block.
  Assumes a single core clock domain and an APB master that presents a 12-bit local byte address.
*/
`default_nettype none
package dsgc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] RUN_CFG_OFF = 12'h060;
  localparam logic [11:0] RUN_GATE_OFF = 12'h108;
  localparam logic [11:0] SLEEP_GATE_OFF = 12'h118;
  localparam logic [11:0] DEEP_GATE_OFF = 12'h128;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h150;
  localparam logic [11:0] IRQ_ENABLE_OFF = 12'h154;
  localparam logic [11:0] IRQ_CLEAR_OFF = 12'h158;
  localparam int ACG_BIT = 27;
  localparam int PHY_BIT = 30;
  localparam int MAC_BIT = 28;
  localparam int PORT_MSB = 6;
  localparam int NUM_UNITS = 9;
  localparam int UNIT_PHY = 8;
  localparam int UNIT_MAC = 7;
  localparam logic [31:0] GATE_MASK = 32'h5000007F;
  localparam logic [31:0] GATE_RESET = 32'h00000000;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  localparam int NUM_EVT = 3;
  localparam int EVT_FAULT = 0;
  localparam int EVT_DEEP = 1;
  localparam int EVT_WAKE = 2;
  localparam logic [NUM_EVT-1:0] EVT_RESET = 3'h0;

  typedef enum logic [2:0] {
    DSGC_RUN = 3'b001,
    DSGC_SLEEP = 3'b010,
    DSGC_DEEP = 3'b100
  } dsgc_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } dsgc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dsgc_apb_rsp_t;

  typedef struct packed {
    logic [31:0] run_gate;
    logic [31:0] sleep_gate;
    logic [31:0] deep_gate;
    logic auto_gating_select;
    logic [NUM_EVT-1:0] irq_status;
    logic [NUM_EVT-1:0] irq_enable;
    logic [NUM_UNITS-1:0] clk_en;
    dsgc_mode_t mode;
    logic rsp_ok;
    logic pslverr;
    logic [31:0] prdata;
  } dsgc_state_t;

  localparam dsgc_state_t DSGC_STATE_RESET = '{
    run_gate: GATE_RESET, sleep_gate: GATE_RESET, deep_gate: GATE_RESET, auto_gating_select: 1'b0,
    irq_status: EVT_RESET, irq_enable: EVT_RESET, clk_en: 9'h000, mode: DSGC_RUN,
    rsp_ok: 1'b0, pslverr: 1'b0, prdata: READ_ZERO};

  // one unit enable per implemented register bit, ports in the low bits
  function automatic logic [NUM_UNITS-1:0] dsgc_units(input logic [31:0] g);
    return {g[PHY_BIT], g[MAC_BIT], g[PORT_MSB:0]};
  endfunction : dsgc_units
endpackage : dsgc_pkg
`default_nettype wire

// [tb/test_deep_sleep_clock_gating_control.sv]
/* Self-checking bench for dsgc_gate_ctrl: APB registers, gating mode selection, faults, irq.
   Assumes APB answers within 16 cycles; core_ce is dropped once to check the freeze. */
`default_nettype none
module test_deep_sleep_clock_gating_control import dsgc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic core_ce = 1'b1;
  logic sleep_now = 1'b0;
  logic deep_now = 1'b0;
  logic [NUM_UNITS-1:0] unit_sel = '0;
  dsgc_apb_req_t req = '0;
  dsgc_apb_rsp_t rsp;
  logic [NUM_UNITS-1:0] clk_en;
  logic [NUM_UNITS-1:0] fault;
  logic irq;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int comparisons = 0;

  dsgc_gate_ctrl u_dut (.core_clk(core_clk), .resetn(resetn), .core_ce(core_ce), .apb_req(req),
    .apb_rsp(rsp), .sleep_now(sleep_now), .deep_now(deep_now), .unit_sel(unit_sel),
    .unit_clk_en(clk_en), .unit_fault(fault), .irq(irq));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // pready, prdata and pslverr are taken at the rising edge that completes the access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (rsp.pready !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask : rdchk

  task automatic t_reset();
    unit_sel <= 9'h1FF;
    @(posedge core_clk);
    #1;
    chk("clk_en", 32'(clk_en), 32'h0);
    chk("fault", 32'(fault), 32'h1FF);
    rdchk("deep", DEEP_GATE_OFF, 32'h0);
    unit_sel <= '0;
  endtask : t_reset

  task automatic t_regs();
    apb(1'b1, DEEP_GATE_OFF, 32'hAFFFFF80);
    rdchk("deep rsvd", DEEP_GATE_OFF, 32'h0);
    apb(1'b1, DEEP_GATE_OFF, 32'hFFFFFFFF);
    rdchk("deep all", DEEP_GATE_OFF, 32'h5000007F);
    apb(1'b0, 12'h124, 32'h0);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0);
  endtask : t_regs

  // gating follows the selected register one edge after the change
  task automatic mode(input logic auto_gating_select, input logic s, input logic dp, input logic [8:0] exp);
    apb(1'b1, RUN_CFG_OFF, {4'h0, auto_gating_select, 27'h0});
    sleep_now <= s;
    deep_now <= dp;
    repeat (2) @(posedge core_clk);
    #1;
    chk("clk_en", 32'(clk_en), 32'(exp));
  endtask : mode

  task automatic t_fault();
    apb(1'b1, IRQ_ENABLE_OFF, 32'h0);
    apb(1'b1, IRQ_CLEAR_OFF, 32'h7);
    unit_sel <= 9'h1FF;
    @(posedge core_clk);
    #1;
    chk("fault", 32'(fault), 32'h1FE);
    @(posedge core_clk);
    unit_sel <= '0;
    #1;
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, IRQ_STATUS_OFF, 32'h0);
    rdchk("status", IRQ_STATUS_OFF, 32'h1);
    apb(1'b1, IRQ_ENABLE_OFF, 32'h1);
    #1;
    chk("irq", 32'(irq), 32'h1);
    apb(1'b1, IRQ_CLEAR_OFF, 32'h1);
    #1;
    chk("irq clr", 32'(irq), 32'h0);
    rdchk("status clr", IRQ_STATUS_OFF, 32'h0);
  endtask : t_fault

  // a low clock enable must hold the gating outputs through a mode change
  task automatic t_freeze();
    mode(1'b1, 1'b1, 1'b1, 9'h140);
    @(posedge core_clk);
    core_ce <= 1'b0;
    deep_now <= 1'b0;
    sleep_now <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("frozen clk_en", 32'(clk_en), 32'h140);
    @(posedge core_clk);
    core_ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("thawed clk_en", 32'(clk_en), 32'h001);
  endtask : t_freeze

  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    // units used below get their enables first
    apb(1'b1, RUN_GATE_OFF, 32'h00000001);
    apb(1'b1, SLEEP_GATE_OFF, 32'h10000000);
    apb(1'b1, DEEP_GATE_OFF, 32'h40000040);
    mode(1'b1, 1'b0, 1'b1, 9'h140);
    mode(1'b1, 1'b1, 1'b0, 9'h080);
    mode(1'b1, 1'b0, 1'b0, 9'h001);
    mode(1'b0, 1'b1, 1'b1, 9'h001);
    t_fault();
    t_freeze();
    end_sim();
  end
endmodule : test_deep_sleep_clock_gating_control
`default_nettype wire
